// ### lpwt_pkg.sv
// constants, register map and field layout of the wake-up interval timer
package lpwt_pkg;

	// ----------------------------------------
	// register map (byte offsets)
	// ----------------------------------------
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_CMP     = 12'h004;
	localparam logic [11:0] OFS_COUNT   = 12'h008;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int          BIT_RUN     = 15;
	localparam int          BIT_MIEN    = 7;
	localparam int          BIT_FLAG    = 3;
	localparam int          BIT_CLR     = 0;

	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [15:0] RST_CMP     = 16'hffff;
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [15:0] CMP_MIN     = 16'h0001;

	// ----------------------------------------
	// counting clock
	// ----------------------------------------
	localparam int          RC_OSC_HZ   = 100;
	localparam int          OSC_DIV     = 32;
	localparam logic [4:0]  DIV_LAST    = 5'h1f;
	localparam logic [4:0]  DIV_HALF    = 5'h10;
	localparam logic [4:0]  DIV_ZERO    = 5'h00;

endpackage : lpwt_pkg

// ### lpwt_if.sv
// carrier between the register side, the clock divider and the counter
interface lpwt_if;
	logic        run;
	logic        clear;
	logic [15:0] cmp;
	logic        tick;
	logic [15:0] count;
	logic        match;

	modport ctl (output run, output clear, output cmp, input tick, input count, input match);
	modport cnt (input run, input clear, input cmp, input tick, output count, output match);
	modport dvr (input run, output tick);
endinterface : lpwt_if

// ### lpwt_div.sv
// rc oscillator synchroniser and divide-by-32 counting clock
module lpwt_div
	import lpwt_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic periph_reset,
	input  wire logic rc_osc_in,
	lpwt_if.dvr       bus
);

	logic [2:0] osc_sync_r;
	logic [4:0] div_r;
	logic [4:0] div_nxt;
	logic       first_r;
	logic       first_nxt;
	logic       tick_r;
	logic       tick_nxt;
	logic       osc_rise;

	// osc_sync_r[0] feeds only osc_sync_r[1]
	assign osc_rise = osc_sync_r[1] & ~osc_sync_r[2];

	always_comb
	begin
		div_nxt   = div_r;
		first_nxt = first_r;
		tick_nxt  = 1'b0;
		if (periph_reset)
		begin
			first_nxt = 1'b1;
			div_nxt   = DIV_ZERO;
		end
		else if (!bus.run)
			// oscillator is off; first start after reset begins mid-period
			div_nxt = first_r ? DIV_HALF : DIV_ZERO;
		else if (osc_rise)
		begin
			first_nxt = 1'b0;
			tick_nxt  = (div_r == DIV_LAST);
			div_nxt   = 5'(div_r + 5'h01);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			osc_sync_r <= 3'h0;
			div_r      <= DIV_HALF;
			first_r    <= 1'b1;
			tick_r     <= 1'b0;
		end
		else
		begin
			osc_sync_r <= {osc_sync_r[1:0], rc_osc_in};
			div_r      <= div_nxt;
			first_r    <= first_nxt;
			tick_r     <= tick_nxt;
		end
	end

	assign bus.tick = tick_r;

	default clocking dck @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	tick_spacing_a: assert property (tick_r |=> !tick_r [*8])
		else $error("count ticks closer than the divider allows");
	osc_off_a: assert property (!bus.run |=> !tick_r)
		else $error("tick while oscillator is stopped");

endmodule : lpwt_div

// ### lpwt_core.sv
// 16-bit up-counter with compare match and wrap to zero
module lpwt_core
	import lpwt_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic periph_reset,
	lpwt_if.cnt       bus
);

	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic        match_r;
	logic        match_nxt;

	always_comb
	begin
		count_nxt = count_r;
		match_nxt = 1'b0;
		if (periph_reset || bus.clear)
			count_nxt = RST_COUNT;
		else if (bus.run && bus.tick)
		begin
			if (count_r == bus.cmp)
			begin
				count_nxt = RST_COUNT;
				match_nxt = 1'b1;
			end
			else
				count_nxt = 16'(count_r + 16'h0001);
		end
	end

	// reset_n, periph_reset and the clear command all zero the counter; shutdown wake leaves it be
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_r <= RST_COUNT;
			match_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			match_r <= match_nxt;
		end
	end

	assign bus.count = count_r;
	assign bus.match = match_r;

	default clocking cck @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_step;
		bus.run && bus.tick && !bus.clear && !periph_reset;
	endsequence

	count_inc_a: assert property (s_step and count_r != bus.cmp |=> count_r == $past(count_r) + 16'h0001)
		else $error("counter did not advance by one");
	wrap_match_a: assert property (s_step and count_r == bus.cmp |=> count_r == 16'h0000 && match_r)
		else $error("counter did not wrap with a match");
	count_hold_a: assert property (!bus.tick && !bus.clear && !periph_reset |=> $stable(count_r))
		else $error("counter moved without a tick");
	clear_zero_a: assert property (bus.clear |=> count_r == 16'h0000)
		else $error("clear did not zero the counter");

endmodule : lpwt_core

// ### lpwt_top.sv
// low-power wake-up interval timer: apb registers, flag, interrupt and wake
//
// Contract
// - the run bit at 15 starts the counter and the rc oscillator, and clearing it stops both.
// - control bit 7 lets the match interrupt out only while it is one.
// - control bit 3 is set on a match and cleared only by writing one to it, by periph_reset or by reset_n.
// - writing one to bit 0 zeroes the counter and the bit then drops by itself.
// - compare data spans 0x0001 to 0xffff, resets to 0xffff, and a period is data plus one ticks.
// - the counter steps by one on each counting-clock edge while the run bit is set.
// - the counting clock is the roughly 100 hz rc oscillator divided by 32.
// - control, compare and count keep their contents across a wake from shutdown.
// - the first enable after a reset may match half a counting period early.
// - the timer is only a periodic 16-bit interval timer with no other modes.
// - a match serves as a wake-up request out of the shutdown state.
// - all three registers are 32 bits wide and take word, halfword and byte access.
module lpwt_top
	import lpwt_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rc_osc_in,
	input  wire logic              periph_reset,
	output logic                   osc_run,
	output logic                   match_irq,
	output logic                   wake_req
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic        run_r;
	logic        run_nxt;
	logic        mien_r;
	logic        mien_nxt;
	logic        flag_r;
	logic        flag_nxt;
	logic        clr_r;
	logic        clr_nxt;
	logic [15:0] cmp_r;
	logic [15:0] cmp_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        ready_r;
	logic        ready_nxt;
	logic        err_r;
	logic        err_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic        wake_r;
	logic        wake_nxt;

	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] ctrl_word;
	logic [31:0] cmp_merged;
	logic        setup;
	logic        wr_go;
	logic        ctl_wr;
	logic        cmp_wr;
	logic        mapped;

	lpwt_if bus ();

	// ----------------------------------------
	// sub-blocks
	// ----------------------------------------
	lpwt_div u_div (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.periph_reset (periph_reset),
		.rc_osc_in    (rc_osc_in),
		.bus          (bus.dvr)
	);

	lpwt_core u_core (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.periph_reset (periph_reset),
		.bus          (bus.cnt)
	);

	// ----------------------------------------
	// byte lanes
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
		end
	endgenerate

	assign wbits     = pwdata & wmask;
	assign ctrl_word = {16'h0000, run_r, 7'h00, mien_r, 3'h0, flag_r, 2'h0, clr_r};
	// only the interval-timer fields exist; every other bit reads zero
	assign cmp_merged = ({16'h0000, cmp_r} & ~wmask) | wbits;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	// no wait state: pready and prdata come from flops loaded in the setup phase
	assign setup  = psel && !penable;
	assign wr_go  = psel && penable && pwrite && ready_r;
	assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CMP) || (paddr == OFS_COUNT);
	assign ctl_wr = wr_go && (paddr == OFS_CTRL);
	assign cmp_wr = wr_go && (paddr == OFS_CMP);

	always_comb
	begin
		ready_nxt = setup;
		err_nxt   = setup && !mapped;
		rdata_nxt = 32'h0000_0000;
		if (setup && !pwrite)
		begin
			unique case (paddr)
				OFS_CTRL:  rdata_nxt = ctrl_word;
				OFS_CMP:   rdata_nxt = {16'h0000, cmp_r};
				OFS_COUNT: rdata_nxt = {16'h0000, bus.count};
				default:   rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// control and compare registers
	// ----------------------------------------
	always_comb
	begin
		run_nxt  = run_r;
		mien_nxt = mien_r;
		flag_nxt = flag_r;
		clr_nxt  = 1'b0;
		cmp_nxt  = cmp_r;
		if (periph_reset)
		begin
			run_nxt  = RST_CTRL[BIT_RUN];
			mien_nxt = RST_CTRL[BIT_MIEN];
			flag_nxt = RST_CTRL[BIT_FLAG];
			cmp_nxt  = RST_CMP;
		end
		else
		begin
			if (ctl_wr && pstrb[1])
				run_nxt = pwdata[BIT_RUN];
			if (ctl_wr && pstrb[0])
				mien_nxt = pwdata[BIT_MIEN];
			if (ctl_wr && wbits[BIT_FLAG])
				flag_nxt = 1'b0;
			// a match in the same cycle beats the software clear
			if (bus.match)
				flag_nxt = 1'b1;
			if (ctl_wr && wbits[BIT_CLR] && !clr_r)
				clr_nxt = 1'b1;
			if (cmp_wr)
				// zero is outside the range; clamp so the period stays defined
				cmp_nxt = (cmp_merged[15:0] == 16'h0000) ? CMP_MIN : cmp_merged[15:0];
		end
		irq_nxt  = flag_r && mien_r;
		wake_nxt = bus.match;
	end

	// only reset_n resets these flops directly; periph_reset reloads the settings through the next state
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_r   <= RST_CTRL[BIT_RUN];
			mien_r  <= RST_CTRL[BIT_MIEN];
			flag_r  <= RST_CTRL[BIT_FLAG];
			clr_r   <= RST_CTRL[BIT_CLR];
			cmp_r   <= RST_CMP;
			rdata_r <= 32'h0000_0000;
			ready_r <= 1'b0;
			err_r   <= 1'b0;
			irq_r   <= 1'b0;
			wake_r  <= 1'b0;
		end
		else
		begin
			run_r   <= run_nxt;
			mien_r  <= mien_nxt;
			flag_r  <= flag_nxt;
			clr_r   <= clr_nxt;
			cmp_r   <= cmp_nxt;
			rdata_r <= rdata_nxt;
			ready_r <= ready_nxt;
			err_r   <= err_nxt;
			irq_r   <= irq_nxt;
			wake_r  <= wake_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus.run   = run_r;
	assign bus.clear = clr_r;
	assign bus.cmp   = cmp_r;

	assign prdata    = rdata_r;
	assign pready    = ready_r;
	assign pslverr   = err_r;
	assign osc_run   = run_r;
	assign match_irq = irq_r;
	assign wake_req  = wake_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking tck @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_flag_w1;
		ctl_wr && pwdata[BIT_FLAG] && pstrb[0];
	endsequence

	flag_set_a: assert property (bus.match && !periph_reset |=> flag_r)
		else $error("match did not set the flag");
	flag_w1c_a: assert property (s_flag_w1 and !bus.match && !periph_reset |=> !flag_r)
		else $error("writing one did not clear the flag");
	flag_keep_a: assert property (flag_r && !bus.match && !periph_reset
		&& !(ctl_wr && wbits[BIT_FLAG]) |=> flag_r)
		else $error("flag dropped without a write of one");
	irq_gate_a: assert property (match_irq |-> $past(mien_r) && $past(flag_r))
		else $error("interrupt raised while gated off");
	clr_self_a: assert property (clr_r |=> !clr_r ##1 (!clr_r || $past(ctl_wr)))
		else $error("clear command did not drop by itself");
	run_osc_a: assert property (ctl_wr && pstrb[1] && !periph_reset |=> osc_run == $past(pwdata[BIT_RUN]))
		else $error("oscillator power does not follow the run bit");
	wake_pulse_a: assert property (bus.match |=> wake_req)
		else $error("match gave no wake request");
	cmp_range_a: assert property (cmp_r != 16'h0000)
		else $error("compare data left its range");
	apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("access phase did not complete in one cycle");

endmodule : lpwt_top

// ### lpwt_top_tb.sv
// self-checking testbench of the wake-up interval timer
module lpwt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lpwt_pkg::*;

	// ----------------------------------------
	// stimulus and design
	// ----------------------------------------
	logic              core_clk;
	logic              reset_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [3:0]        pstrb;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              rc_osc_in;
	logic              periph_reset;
	logic              osc_run;
	logic              match_irq;
	logic              wake_req;
	logic [2:0]        osc_cnt;
	logic [31:0]       rdat;
	logic              rerr;
	logic [31:0]       shadow;
	logic [31:0]       d;
	logic [15:0]       cmp;
	int                error_cnt;
	int                n_checks;
	int                n;
	int                per;

	lpwt_top i_lpwt_top (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rc_osc_in(rc_osc_in), .periph_reset(periph_reset), .osc_run(osc_run),
		.match_irq(match_irq), .wake_req(wake_req));

	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	// osc edge every 8 clocks keeps the tick spacing exact: 256 clocks
	always @(posedge core_clk)
	begin
		osc_cnt   <= osc_cnt + 3'h1;
		rc_osc_in <= osc_cnt[2];
	end

	// ----------------------------------------
	// tasks and functions
	// ----------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// pready and read data are taken at the rising edge that sees pready high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] dat,
		input logic [3:0] s);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= dat;
		pstrb   <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		// no wait limit here: only the watchdog ends a hung access
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wait_wake(output int cyc);
		cyc = 0;
		while (cyc < 20000)
		begin
			@(negedge core_clk);
			if (wake_req === 1'b1)
				break;
			cyc++;
		end
		if (cyc >= 20000)
		begin
			check("wake_req", 32'h0, 32'h1);
			end_of_test();
		end
	endtask : wait_wake

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] v,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		if (s[0])
			r[7:0] = v[7:0];
		if (s[1])
			r[15:8] = v[15:8];
		r[31:16] = 16'h0000;
		if (r[15:0] == 16'h0000)
			r = 32'h0000_0001;
		return r;
	endfunction : merge

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		end_of_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{reset_n, psel, penable, pwrite, periph_reset, osc_cnt} = '0;
		{paddr, pwdata, pstrb, rc_osc_in, error_cnt, n_checks} = '0;
		void'($urandom(59895));
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		apb(0, OFS_CTRL, 0, 4'hf);  check("ctrl_rst", rdat, RST_CTRL);
		apb(0, OFS_CMP, 0, 4'hf);   check("cmp_rst", rdat, 32'h0000_ffff);
		apb(0, OFS_COUNT, 0, 4'hf); check("cnt_rst", rdat, 32'h0);
		check("no_err", {31'h0, rerr}, 32'h0);
		apb(0, 12'h00c, 0, 4'hf);   check("unmapped", rdat, 32'h0);
		check("slverr", {31'h0, rerr}, 32'h1);
		apb(1, OFS_COUNT, 32'hffff, 4'hf); apb(0, OFS_COUNT, 0, 4'hf);
		check("cnt_ro", rdat, 32'h0);
		$display("test reset done");
		shadow = 32'h0000_ffff;
		for (int i = 0; i < 10; i++)
		begin
			d = (i == 0) ? 32'h0 : $urandom;
			n = (i < 2) ? 15 : 1 + $urandom % 15;
			apb(1, OFS_CMP, d, n[3:0]);
			shadow = merge(shadow, d, n[3:0]);
			apb(0, OFS_CMP, 0, 4'hf); check("cmp_rw", rdat, shadow);
		end
		$display("test compare done");
		cmp = 16'h3 + 16'($urandom % 4);
		apb(1, OFS_CMP, {16'h0, cmp}, 4'hf);
		apb(1, OFS_CTRL, 32'h8080, 4'hf);
		@(negedge core_clk);
		check("osc_run", {31'h0, osc_run}, 32'h1);
		wait_wake(n);
		per = (int'(cmp) + 1) * 256;
		check("first_half", {31'h0, n > per - 180 && n < per - 100}, 32'h1);
		wait_wake(n);
		check("period", n + 1, per);
		apb(0, OFS_CTRL, 0, 4'hf); check("flag_set", rdat, 32'h8088);
		check("irq_on", {31'h0, match_irq}, 32'h1);
		apb(1, OFS_CTRL, 32'h8080, 4'hf); apb(0, OFS_CTRL, 0, 4'hf);
		check("flag_keep", rdat, 32'h8088);
		apb(1, OFS_CTRL, 32'h8088, 4'hf); apb(0, OFS_CTRL, 0, 4'hf);
		check("flag_clr", rdat, 32'h8080);
		check("irq_off", {31'h0, match_irq}, 32'h0);
		$display("test run done");
		wait_wake(n);
		repeat (562) @(posedge core_clk);
		apb(0, OFS_COUNT, 0, 4'hf); check("cnt_two", rdat, 32'h2);
		apb(1, OFS_CTRL, 32'h8081, 4'hf); apb(0, OFS_CTRL, 0, 4'hf);
		check("clr_drop", rdat, 32'h8088);
		apb(0, OFS_COUNT, 0, 4'hf); check("cnt_clr", rdat, 32'h0);
		$display("test clear done");
		repeat (300) @(posedge core_clk);
		apb(1, OFS_CTRL, 32'h0008, 4'hf);
		@(negedge core_clk);
		check("osc_stop", {31'h0, osc_run}, 32'h0);
		apb(0, OFS_COUNT, 0, 4'hf); d = rdat;
		repeat (600) @(posedge core_clk);
		apb(0, OFS_COUNT, 0, 4'hf); check("cnt_hold", rdat, d);
		apb(1, OFS_CTRL, 32'h8000, 4'hf);
		wait_wake(n);
		repeat (4) @(posedge core_clk);
		check("irq_masked", {31'h0, match_irq}, 32'h0);
		apb(0, OFS_CTRL, 0, 4'hf); check("flag_masked", rdat, 32'h8008);
		$display("test mask done");
		@(posedge core_clk);
		periph_reset <= 1'b1;
		@(posedge core_clk);
		periph_reset <= 1'b0;
		apb(0, OFS_CTRL, 0, 4'hf);  check("prst_ctrl", rdat, 32'h0);
		apb(0, OFS_CMP, 0, 4'hf);   check("prst_cmp", rdat, 32'h0000_ffff);
		apb(0, OFS_COUNT, 0, 4'hf); check("prst_cnt", rdat, 32'h0);
		apb(1, OFS_CMP, {16'h0, cmp}, 4'hf);
		apb(1, OFS_CTRL, 32'h8000, 4'hf);
		wait_wake(n);
		check("prst_half", {31'h0, n > per - 180 && n < per - 100}, 32'h1);
		$display("test periph reset done");
		end_of_test();
	end

endmodule : lpwt_top_tb
